/* File: rtl/ttbt_defines.vh */
// Constants for the transmit backplane timing block
`ifndef TTBT_DEFINES_VH
`define TTBT_DEFINES_VH
// Register byte addresses
`define TTBT_ADDR_CTRL      12'h000
`define TTBT_ADDR_BLOCK     12'h004
`define TTBT_ADDR_GATE      12'h008
`define TTBT_ADDR_NCO       12'h00c
`define TTBT_ADDR_STATUS    12'h010
// Control fields
`define TTBT_CTRL_E1        0
`define TTBT_CTRL_ELASTIC   1
`define TTBT_CTRL_INTCLK    2
`define TTBT_CTRL_GATED     3
`define TTBT_CTRL_ESF       4
`define TTBT_CTRL_IBO_EN    5
`define TTBT_CTRL_IBO_SEL   7:6
`define TTBT_CTRL_IBO_POS   10:8
`define TTBT_CTRL_WIDTH     11
`define TTBT_CTRL_RESET     11'h000
`define TTBT_MASK_RESET     32'h00000000
// NCO step for 1.544 MHz from the 20 MHz clock (2^32 * 1.544 / 20)
`define TTBT_NCO_RESET      32'h13c3615f
// Frame structure
`define TTBT_BIT_LAST       3'h7
`define TTBT_CHANS_T1       9'h018
`define TTBT_CHANS_E1       9'h020
`define TTBT_MF_LAST_SF     5'h0b
`define TTBT_MF_LAST_ESF    5'h17
`define TTBT_MF_LAST_E1     5'h0f
// Synchroniser input indices
`define TTBT_SYN_LINE       0
`define TTBT_SYN_SYS        1
`define TTBT_SYN_DATA       2
`define TTBT_SYN_FSYNC      3
`define TTBT_SYN_NUM        4
`endif

/* File: rtl/ttbt_top.v */
// Transmit backplane timing: channel clock, channel block and serial capture
//
// Summary of operation
// - A T1 frame is one framing bit then 24 eight-bit channels.
// - Channel bits go MSB first; bit 8, the LSB, goes last.
// - Superframe groups 12 frames, extended superframe groups 24 frames.
// - Without elastic store, serial input sampled on falling line clock edge.
// - With elastic store, serial input sampled on falling system clock edge.
// - Channel clock pulses high during each channel LSB.
// - Channel clock may instead output a per-channel gated bit clock.
// - Channel outputs follow line clock, or system clock with elastic store.
// - Channel block level is programmable for every channel.
// - Formatter timing runs from a 1.544 or 2.048 MHz line clock.
// - Line clock may be derived internally from the master clock.
// - System clock used only with elastic store; several backplane rates.
// - Master clock serves T1 and E1 alike.
// - Elastic store setting only moves timing to the system clock; there is no buffer or slip handling.
// - Interleaved bus lets up to eight ports share one backplane.
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`include "ttbt_defines.vh"

module ttbt_top
(
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        tx_line_clock,
    input  wire        tx_system_clock,
    input  wire        tx_serial_in,
    input  wire        tx_frame_sync,
    output reg         tx_chan_clock,
    output reg         tx_chan_block
);

    reg  [`TTBT_CTRL_WIDTH-1:0] ctrl_q;
    reg  [31:0]                 block_q;
    reg  [31:0]                 gate_q;
    reg  [31:0]                 nco_step_q;
    reg  [31:0]                 nco_acc_q;
    reg                         nco_msb_q;
    reg                         fbit_q;
    reg  [7:0]                  chan_q;
    reg  [2:0]                  bit_q;
    reg  [4:0]                  mf_q;
    reg                         sync_pend_q;
    reg  [6:0]                  shift_q;
    reg  [7:0]                  last_byte_q;
    reg  [7:0]                  last_chan_q;

    wire [`TTBT_SYN_NUM-1:0]    syn_in;
    wire [`TTBT_SYN_NUM-1:0]    syn_now;
    wire [`TTBT_SYN_NUM-1:0]    syn_prev;

    assign syn_in[`TTBT_SYN_LINE]  = tx_line_clock;
    assign syn_in[`TTBT_SYN_SYS]   = tx_system_clock;
    assign syn_in[`TTBT_SYN_DATA]  = tx_serial_in;
    assign syn_in[`TTBT_SYN_FSYNC] = tx_frame_sync;

    // Three-stage synchronisers for all pins from outside the pclk domain
    genvar gi;
    generate
        for (gi = 0; gi < `TTBT_SYN_NUM; gi = gi + 1)
        begin : g_sync
            reg s1_q;
            reg s2_q;
            reg s3_q;
            reg val_q;
            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    s1_q  <= 1'b0;
                    s2_q  <= 1'b0;
                    s3_q  <= 1'b0;
                    val_q <= 1'b0;
                end
                else
                begin
                    s1_q <= syn_in[gi];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    // A new level counts only once two stages agree
                    if (s2_q == s3_q)
                    begin
                        val_q <= s3_q;
                    end
                end
            end
            assign syn_now[gi]  = (s2_q == s3_q) ? s3_q : val_q;
            assign syn_prev[gi] = val_q;
        end
    endgenerate

    wire e1_mode    = ctrl_q[`TTBT_CTRL_E1];
    wire elastic_en = ctrl_q[`TTBT_CTRL_ELASTIC];
    wire int_clk    = ctrl_q[`TTBT_CTRL_INTCLK];
    wire gated_mode = ctrl_q[`TTBT_CTRL_GATED];
    wire esf_mode   = ctrl_q[`TTBT_CTRL_ESF];
    wire ibo_en     = ctrl_q[`TTBT_CTRL_IBO_EN];
    wire [1:0] ibo_sel = ctrl_q[`TTBT_CTRL_IBO_SEL];
    wire [2:0] ibo_pos = ctrl_q[`TTBT_CTRL_IBO_POS];

    // Master-clock NCO standing in for the internally sourced line clock
    wire [31:0] nco_next = nco_acc_q + nco_step_q;

    // Clock source selection and edge detection
    // Pin clock edges come from the filtered level, a few pclk late
    reg clk_prev;
    reg clk_now;
    always @*
    begin
        if (elastic_en)
        begin
            clk_prev = syn_prev[`TTBT_SYN_SYS];
            clk_now  = syn_now[`TTBT_SYN_SYS];
        end
        else if (int_clk)
        begin
            clk_prev = nco_msb_q;
            clk_now  = nco_acc_q[31];
        end
        else
        begin
            clk_prev = syn_prev[`TTBT_SYN_LINE];
            clk_now  = syn_now[`TTBT_SYN_LINE];
        end
    end

    wire rise_e  = clk_now & ~clk_prev;
    wire fall_e  = ~clk_now & clk_prev;
    wire clk_lvl = clk_prev;

    // Frame geometry
    // E1 and interleaved frames carry no framing bit
    wire       has_fbit  = ~e1_mode & ~ibo_en;
    wire [8:0] chan_base = (e1_mode | ibo_en) ? `TTBT_CHANS_E1 : `TTBT_CHANS_T1;
    wire [8:0] chan_tot  = ibo_en ? (chan_base << ibo_sel) : chan_base;
    wire [8:0] chan_lm1  = chan_tot - 9'h001;
    wire [7:0] chan_last = chan_lm1[7:0];
    // Multiframe wraps at 12, 24 or 16 frames
    wire [4:0] mf_last   = e1_mode ? `TTBT_MF_LAST_E1 :
                           (esf_mode ? `TTBT_MF_LAST_ESF : `TTBT_MF_LAST_SF);

    // Interleave: port slot is the low channel bits, local channel the rest
    wire [7:0] port_mask = ibo_en ? ((8'h01 << ibo_sel) - 8'h01) : 8'h00;
    wire [7:0] chan_shr  = chan_q >> ibo_sel;
    wire [4:0] local_ch  = ibo_en ? chan_shr[4:0] : chan_q[4:0];
    wire       own_slot  = ((chan_q & port_mask) == ({5'h00, ibo_pos} & port_mask));
    wire       is_lsb    = ~fbit_q & (bit_q == `TTBT_BIT_LAST);

    // Bit, channel and multiframe counters
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            // Counters start at channel 0, bit 0
            fbit_q      <= 1'b0;
            chan_q      <= 8'h00;
            bit_q       <= 3'h0;
            mf_q        <= 5'h00;
            sync_pend_q <= 1'b0;
        end
        else
        begin
            // Sync seen at a fall acts on the next rise
            if (fall_e && syn_prev[`TTBT_SYN_FSYNC])
            begin
                sync_pend_q <= 1'b1;
            end
            if (rise_e)
            begin
                if (sync_pend_q)
                begin
                    sync_pend_q <= 1'b0;
                    fbit_q      <= has_fbit;
                    chan_q      <= 8'h00;
                    bit_q       <= 3'h0;
                    mf_q        <= (mf_q >= mf_last) ? 5'h00 : mf_q + 5'h01;
                end
                else if (fbit_q)
                begin
                    fbit_q <= 1'b0;
                end
                else if (bit_q == `TTBT_BIT_LAST)
                begin
                    bit_q <= 3'h0;
                    if (chan_q >= chan_last)
                    begin
                        chan_q <= 8'h00;
                        fbit_q <= has_fbit;
                        mf_q   <= (mf_q >= mf_last) ? 5'h00 : mf_q + 5'h01;
                    end
                    else
                    begin
                        chan_q <= chan_q + 8'h01;
                    end
                end
                else
                begin
                    bit_q <= bit_q + 3'h1;
                end
            end
        end
    end

    // Serial capture, MSB first, on the falling edge of the selected clock
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            shift_q     <= 7'h00;
            last_byte_q <= 8'h00;
            last_chan_q <= 8'h00;
        end
        // Framing bit is not part of any byte
        else if (fall_e && !fbit_q)
        begin
            shift_q <= {shift_q[5:0], syn_prev[`TTBT_SYN_DATA]};
            if (bit_q == `TTBT_BIT_LAST)
            begin
                last_byte_q <= {shift_q, syn_prev[`TTBT_SYN_DATA]};
                last_chan_q <= chan_q;
            end
        end
    end

    // Channel clock and channel block outputs
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_chan_clock <= 1'b0;
            tx_chan_block <= 1'b0;
        end
        else
        begin
            if (gated_mode)
            begin
                // Gated bit clock follows the selected clock level
                tx_chan_clock <= clk_lvl & ~fbit_q & own_slot & gate_q[local_ch];
            end
            else
            begin
                tx_chan_clock <= is_lsb & own_slot;
            end
            tx_chan_block <= ~fbit_q & own_slot & block_q[local_ch];
        end
    end

    // NCO
    // Accumulator MSB is the internal line clock
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            nco_acc_q <= 32'h00000000;
            nco_msb_q <= 1'b0;
        end
        else
        begin
            nco_acc_q <= nco_next;
            nco_msb_q <= nco_acc_q[31];
        end
    end

    // APB slave: one wait-free access phase, read data registered at setup
    wire setup_ph = psel & ~penable;
    wire wr_en    = psel & penable & pready & pwrite;
    wire mapped   = (paddr == `TTBT_ADDR_CTRL) | (paddr == `TTBT_ADDR_BLOCK) |
                    (paddr == `TTBT_ADDR_GATE) | (paddr == `TTBT_ADDR_NCO) |
                    (paddr == `TTBT_ADDR_STATUS);

    reg [31:0] rd_mux;
    always @*
    begin
        case (paddr)
            `TTBT_ADDR_CTRL:   rd_mux = {21'h000000, ctrl_q};
            `TTBT_ADDR_BLOCK:  rd_mux = block_q;
            `TTBT_ADDR_GATE:   rd_mux = gate_q;
            `TTBT_ADDR_NCO:    rd_mux = nco_step_q;
            `TTBT_ADDR_STATUS: rd_mux = {mf_q, chan_q, bit_q, last_chan_q, last_byte_q};
            default:           rd_mux = 32'h00000000;
        endcase
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end
        else
        begin
            pready  <= setup_ph;
            // Unmapped offsets answer with an error
            pslverr <= setup_ph & ~mapped;
            prdata  <= (setup_ph & ~pwrite) ? rd_mux : 32'h00000000;
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q     <= `TTBT_CTRL_RESET;
            block_q    <= `TTBT_MASK_RESET;
            gate_q     <= `TTBT_MASK_RESET;
            nco_step_q <= `TTBT_NCO_RESET;
        end
        else if (wr_en)
        begin
            case (paddr)
                `TTBT_ADDR_CTRL:  ctrl_q     <= pwdata[`TTBT_CTRL_WIDTH-1:0];
                `TTBT_ADDR_BLOCK: block_q    <= pwdata;
                `TTBT_ADDR_GATE:  gate_q     <= pwdata;
                `TTBT_ADDR_NCO:   nco_step_q <= pwdata;
                // STATUS is read-only; writes are dropped
                default:          ctrl_q     <= ctrl_q;
            endcase
        end
    end

endmodule // ttbt_top

/* File: testbench/ttbt_host_model.sv */
// Host backplane model: clocks, serial payload and frame sync
`timescale 1ns/1ps
module ttbt_host_model
(
    input  wire e1,
    input  wire use_sys,
    output wire tx_line_clock,
    output wire tx_system_clock,
    output reg  tx_serial_in,
    output reg  tx_frame_sync
);
    reg       clk_q;
    reg [8:0] p;
    reg [8:0] q;
    reg [7:0] byte_v;
    initial
    begin
        clk_q = 1'b0;
        p = 9'h000;
        tx_serial_in = 1'b0;
        tx_frame_sync = 1'b0;
    end
    always #200 clk_q = ~clk_q;
    // Unselected clock held low
    assign tx_line_clock   = clk_q & ~use_sys;
    assign tx_system_clock = clk_q & use_sys;
    always @(posedge clk_q)
    begin
        p = (p == (e1 ? 9'h0ff : 9'h0c0)) ? 9'h000 : p + 9'h001;
        q = e1 ? p : p - 9'h001;
        byte_v = {3'h0, q[7:3]} ^ 8'h5a;
        tx_serial_in <= byte_v[~q[2:0]];
        // Sync spans last bit so the next rise starts the frame
        tx_frame_sync <= (p == (e1 ? 9'h0ff : 9'h0c0));
    end
endmodule // ttbt_host_model

/* File: testbench/ttbt_top_props.sv */
// Port assertions for the transmit backplane timing block
`timescale 1ns/1ps
module ttbt_top_props
(
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        tx_line_clock,
    input wire        tx_system_clock,
    input wire        tx_serial_in,
    input wire        tx_frame_sync,
    input wire        tx_chan_clock,
    input wire        tx_chan_block
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    setup_answer_a: assert property (psel && !penable |=> pready) else $error("no answer after setup");
    access_only_a: assert property (pready |-> psel && penable) else $error("answer outside access");
    single_ready_a: assert property (pready |=> !pready) else $error("answer held too long");
    err_ready_a: assert property (pslverr |-> pready) else $error("error without answer");
    idle_data_a: assert property (!pready |-> prdata == 32'h00000000) else $error("read data not idle");
    err_data_a: assert property (pslverr && !pwrite |-> prdata == 32'h00000000) else $error("error read data");
    reset_quiet_a: assert property (@(posedge pclk) disable iff (1'b0) !presetn |-> !pready && !tx_chan_clock
        && !tx_chan_block) else $error("output active in reset");
    pulse_width_a: assert property ($rose(tx_chan_clock) |-> tx_chan_clock [*3]) else $error("short pulse");
endmodule // ttbt_top_props

bind ttbt_top ttbt_top_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_line_clock(tx_line_clock), .tx_system_clock(tx_system_clock), .tx_serial_in(tx_serial_in),
    .tx_frame_sync(tx_frame_sync), .tx_chan_clock(tx_chan_clock), .tx_chan_block(tx_chan_block));

/* File: testbench/ttbt_top_tb.sv */
// Self-checking bench for the transmit backplane timing block
`timescale 1ns/1ps
`include "ttbt_defines.vh"
module ttbt_top_tb;
    reg         pclk = 1'b0;
    reg         presetn = 1'b1;
    reg         psel = 1'b0;
    reg         penable = 1'b0;
    reg         pwrite = 1'b0;
    reg  [11:0] paddr = 12'h000;
    reg  [31:0] pwdata = 32'h00000000;
    reg         e1 = 1'b0;
    reg         use_sys = 1'b0;
    reg         quiet = 1'b0;
    wire [31:0] prdata;
    wire        pready, pslverr, lclk, sclk, ser, fsync, cclk, cblk;
    integer     n_mismatch = 0;
    integer     checks = 0;
    integer     cyc = 0;
    integer     nc, nb;
    reg  [31:0] rd;
    reg         err;
    always #25 pclk = ~pclk;
    ttbt_host_model host (.e1(e1), .use_sys(use_sys), .tx_line_clock(lclk), .tx_system_clock(sclk),
        .tx_serial_in(ser), .tx_frame_sync(fsync));
    ttbt_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_line_clock(lclk), .tx_system_clock(sclk), .tx_serial_in(ser), .tx_frame_sync(fsync & ~quiet),
        .tx_chan_clock(cclk), .tx_chan_block(cblk));
    task tally_and_finish;
    begin
        if (n_mismatch == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
    begin
        checks = checks + 1;
        if (got !== exp)
        begin
            n_mismatch = n_mismatch + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
    begin
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    end
    endtask
    // Counts rising edges of channel clock and block over n cycles
    task count(input integer n);
        reg pc, pb;
    begin
        nc = 0;
        nb = 0;
        pc = cclk;
        pb = cblk;
        repeat (n)
        begin
            @(posedge pclk);
            if (cclk === 1'b1 && pc !== 1'b1) nc = nc + 1;
            if (cblk === 1'b1 && pb !== 1'b1) nb = nb + 1;
            pc = cclk;
            pb = cblk;
        end
    end
    endtask
    // One frame window, offset clear of the sync edge
    task frame(input [31:0] ec, input [31:0] eb);
    begin
        @(posedge fsync);
        @(posedge fsync);
        repeat (16) @(posedge pclk);
        count(e1 ? 2048 : 1544);
        chk(nc, ec);
        chk(nb, eb);
    end
    endtask
    task status;
    begin
        apb(1'b0, `TTBT_ADDR_STATUS, 32'h0);
        chk(rd[7:0], rd[15:8] ^ 8'h5a);
    end
    endtask
    // Twelve frames on, an extended multiframe count sits halfway round
    task esf_span;
        reg [4:0] m0;
    begin
        apb(1'b1, `TTBT_ADDR_CTRL, 32'h12);
        @(posedge fsync);
        repeat (40) @(posedge pclk);
        apb(1'b0, `TTBT_ADDR_STATUS, 32'h0);
        m0 = rd[31:27];
        repeat (12) @(posedge fsync);
        repeat (40) @(posedge pclk);
        apb(1'b0, `TTBT_ADDR_STATUS, 32'h0);
        chk(rd[31:27], (m0 >= 5'h0c) ? m0 - 5'h0c : m0 + 5'h0c);
    end
    endtask
    always @(posedge pclk)
    begin
        cyc = cyc + 1;
        if (cyc == 80000)
        begin
            n_mismatch = n_mismatch + 1;
            tally_and_finish;
        end
    end
    initial
    begin
        presetn <= 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `TTBT_ADDR_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, `TTBT_ADDR_NCO, 32'h0);
        chk(rd, `TTBT_NCO_RESET);
        apb(1'b1, 12'h020, 32'h1);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, `TTBT_ADDR_BLOCK, 32'h80000009);
        frame(32'd24, 32'd2);
        status;
        apb(1'b1, `TTBT_ADDR_GATE, 32'h00000020);
        apb(1'b1, `TTBT_ADDR_CTRL, 32'h8);
        frame(32'd8, 32'd2);
        apb(1'b1, `TTBT_ADDR_CTRL, 32'h1);
        e1 <= 1'b1;
        frame(32'd32, 32'd2);
        // Two-port interleave, odd slots belong to this port
        apb(1'b1, `TTBT_ADDR_CTRL, 32'h160);
        frame(32'd16, 32'd2);
        e1 <= 1'b0;
        use_sys <= 1'b1;
        apb(1'b1, `TTBT_ADDR_CTRL, 32'h2);
        frame(32'd24, 32'd2);
        status;
        esf_span;
        // Host sync is unrelated to the internal clock, so mute it
        quiet <= 1'b1;
        apb(1'b1, `TTBT_ADDR_CTRL, 32'h4);
        repeat (3000) @(posedge pclk);
        count(5000);
        chk({31'h0, nc >= 47 && nc <= 49}, 32'h1);
        tally_and_finish;
    end
endmodule // ttbt_top_tb
